// File: hdl/gate_timer_pkg.sv
// Package for the per-lane gated error measurement timers.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package gate_timer_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_CAP      = 8'h00;
  localparam logic [7:0] OFS_GATE_CTL = 8'h04;
  localparam logic [7:0] OFS_HOST_EN  = 8'h08;
  localparam logic [7:0] OFS_MEDIA_EN = 8'h0c;
  localparam logic [7:0] OFS_BANK     = 8'h10;
  localparam logic [7:0] OFS_FLAGS    = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;

  // ==========================================================================
  // Capability bits
  // ==========================================================================
  localparam int CAP_AUTO_BIT = 2;
  localparam int CAP_BANK_BIT = 3;
  localparam int CAP_RT_BIT   = 4;

  // ==========================================================================
  // Gating control byte fields
  // ==========================================================================
  localparam int GC_RTI_BIT     = 0;
  localparam int GC_NNN_LSB     = 1;
  localparam int GC_AUTO_BIT    = 4;
  localparam int GC_RESTART_BIT = 5;
  localparam int GC_SCOPE_BIT   = 7;

  // ==========================================================================
  // Reset values and timing
  // ==========================================================================
  localparam logic [7:0]  GATE_CTL_RST = 8'h00;
  localparam logic [7:0]  CAP_RST      = 8'h14;
  localparam int          CLK_HZ       = 25000000;
  localparam int          TICK_S       = 1;
  localparam int          TICK_CYC     = CLK_HZ * TICK_S;
  // Real-time refresh period in seconds for interval selector 0 and 1.
  localparam logic [3:0]  RTI_S0       = 4'h1;
  localparam logic [3:0]  RTI_S1       = 4'h5;

endpackage

// File: hdl/gated_prbs_lane_timers.sv
// Per-lane gate timers for checker error measurement, with APB registers.
// Assumes per-lane error pulses from the checkers are synchronous to clk_sys.
//
// What this block does
// - Capability bit shows whether real-time results are readable mid-gate.
// - Gate expiry raises per-lane completion flags when gating is enabled.
// - Unread results are overwritten by the newest gate period's results.
// - Enabling a lane checker zeroes its gate timer and error counter.
// - Every lane owns an independent gate timer.
// - Gate expiry stops counting and publishes results to the first result set.
// - Without real-time capability, results update only at gate end.
// - With real-time capability, results refresh every selected interval.
// - Auto-restart uses control bit 4, needs capability and second result set.
// - In auto-restart, expiry copies results into the second result set.
// - In auto-restart, counters and timer clear and a new period starts.
// - While restart bit is set, enabled lanes freeze counters and timers.
// - Restart release with scope zero restarts enabled lanes of current bank.
// - Restart release with scope one also restarts only enabled lanes of the current bank, as the bank capability bit is clear.
// - Toggling one enable bit affects only that lane.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps

module gated_prbs_lane_timers
  import gate_timer_pkg::*;
#(
  parameter int LANES     = 8,
  parameter int BANKS     = 4,
  parameter int CNT_W     = 24,
  parameter int TICK_CYCS = TICK_CYC
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic                      clk_en,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Checker error pulses, host lanes then media lanes, per bank
  input  wire logic [BANKS*2*LANES-1:0]  err_pulse,
  // Result sets, one word per lane
  output logic [BANKS*2*LANES*CNT_W-1:0] result_live,
  output logic [BANKS*2*LANES*CNT_W-1:0] result_done,
  // Any completion flag set
  output logic                           gate_done_any
);

  localparam int NL = BANKS * 2 * LANES;
  localparam int BW = (BANKS > 1) ? $clog2(BANKS) : 1;
  localparam int NW = (NL + 31) / 32;
  localparam int PW = NW * 32;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0]            gate_ctl_ff;
  logic [BANKS*LANES-1:0] host_en_ff;
  logic [BANKS*LANES-1:0] media_en_ff;
  logic [BW-1:0]         bank_sel_ff;
  logic [BANKS-1:0]      bank_scope_ff;
  logic [NL-1:0]         flag_ff;
  logic                  pready_ff;
  logic [31:0]           prdata_ff;
  logic                  pslverr_ff;
  logic                  gate_any_ff;
  logic [31:0]           tick_cnt_ff;
  logic                  tick_ff;
  logic [3:0]            rt_cnt_ff;
  logic                  rt_tick_ff;
  logic                  restart_q_ff;

  logic [NL-1:0]         flag_set;
  logic [NL-1:0]         nxt_flag;
  logic [NL-1:0]         flag_clr;
  logic [PW-1:0]         flag_pad;
  logic [31:0]           flag_fold;
  logic [NL-1:0]         restart_hit;
  logic                  acc;
  logic                  wr;
  logic                  restart_fall;
  logic                  scope_eff;
  logic                  auto_on;
  logic [2:0]            gate_s;
  logic [3:0]            rt_per;
  logic                  hit;
  logic [31:0]           rd_word;

  localparam logic [7:0] CAP_WORD = CAP_RST;

  assign acc          = psel & penable & ~pready_ff;
  // Writes land at the edge that completes the transfer, as the master sees it.
  assign wr           = psel & penable & pready_ff & pwrite;
  assign gate_s       = gate_ctl_ff[GC_NNN_LSB +: 3];
  assign auto_on      = gate_ctl_ff[GC_AUTO_BIT] & CAP_WORD[CAP_AUTO_BIT];
  assign scope_eff    = gate_ctl_ff[GC_SCOPE_BIT] & CAP_WORD[CAP_BANK_BIT];
  assign restart_fall = restart_q_ff & ~gate_ctl_ff[GC_RESTART_BIT];
  assign rt_per       = gate_ctl_ff[GC_RTI_BIT] ? RTI_S1 : RTI_S0;

  // ==========================================================================
  // APB slave: one wait state, pready is a registered pulse
  // ==========================================================================
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_CAP:      rd_word = {24'h000000, CAP_WORD};
      OFS_GATE_CTL: rd_word = {24'h000000, gate_ctl_ff};
      OFS_HOST_EN:  rd_word = 32'(host_en_ff);
      OFS_MEDIA_EN: rd_word = 32'(media_en_ff);
      OFS_BANK:     rd_word = 32'({bank_scope_ff, 8'(bank_sel_ff)});
      OFS_FLAGS:    rd_word = flag_fold;
      OFS_STATUS:   rd_word = {31'h0000_0000, restart_q_ff};
      default:      hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~hit;
      if (acc & ~pwrite) begin
        prdata_ff <= rd_word;
      end
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gate_ctl_ff   <= GATE_CTL_RST;
      host_en_ff    <= '0;
      media_en_ff   <= '0;
      bank_sel_ff   <= '0;
      bank_scope_ff <= '0;
      restart_q_ff  <= 1'b0;
    end else if (clk_en) begin
      restart_q_ff <= gate_ctl_ff[GC_RESTART_BIT];
      if (wr) begin
        case (paddr)
          OFS_GATE_CTL: gate_ctl_ff <= pwdata[7:0];
          OFS_HOST_EN:  host_en_ff  <= pwdata[BANKS*LANES-1:0];
          OFS_MEDIA_EN: media_en_ff <= pwdata[BANKS*LANES-1:0];
          OFS_BANK: begin
            bank_sel_ff   <= pwdata[BW-1:0];
            bank_scope_ff <= pwdata[8 +: BANKS];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Completion flags
  // ==========================================================================
  // Bit k of the flag word stands for lane k of every 32-lane group, on a read
  // and on a write-one-to-clear alike, so that no lane is left unreachable.
  assign flag_pad = PW'(flag_ff);
  assign flag_clr = NL'({NW{pwdata}});

  always_comb begin
    flag_fold = 32'h0000_0000;
    for (int k = 0; k < NW; k++) begin
      flag_fold = flag_fold | flag_pad[k*32 +: 32];
    end
  end

  // A hardware set wins over a clear written in the same cycle.
  always_comb begin
    nxt_flag = flag_ff | flag_set;
    if (wr && paddr == OFS_FLAGS) begin
      nxt_flag = (flag_ff & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff     <= '0;
      gate_any_ff <= 1'b0;
    end else if (clk_en) begin
      flag_ff     <= nxt_flag;
      // The summary follows the flags at the same edge, clears included.
      gate_any_ff <= |nxt_flag;
    end
  end

  // ==========================================================================
  // one-second tick and real-time refresh tick
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
      rt_cnt_ff   <= '0;
      rt_tick_ff  <= 1'b0;
    end else if (clk_en) begin
      tick_ff    <= 1'b0;
      rt_tick_ff <= 1'b0;
      if (tick_cnt_ff >= 32'(TICK_CYCS - 1)) begin
        tick_cnt_ff <= '0;
        tick_ff     <= 1'b1;
        if (rt_cnt_ff + 4'h1 >= rt_per) begin
          rt_cnt_ff  <= '0;
          rt_tick_ff <= 1'b1;
        end else begin
          rt_cnt_ff <= rt_cnt_ff + 4'h1;
        end
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h1;
      end
    end
  end

  // ==========================================================================
  // Per-lane gate timers, counters and results
  // ==========================================================================
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_lane
      localparam int BK  = gl / (2 * LANES);
      localparam int IDX = gl % (2 * LANES);
      localparam int BIT = BK * LANES + (IDX % LANES);
      logic             en;
      logic             en_q_ff;
      logic [2:0]       sec_ff;
      logic             run_ff;
      logic [CNT_W-1:0] err_ff;
      logic [CNT_W-1:0] live_ff;
      logic [CNT_W-1:0] done_ff;
      logic             expire;
      logic             frozen;
      logic             start;
      logic             publish;
      logic             active;

      assign en = (IDX < LANES) ? host_en_ff[BIT] : media_en_ff[BIT];
      assign restart_hit[gl] = en & restart_fall &
                               (scope_eff ? bank_scope_ff[BK] : (bank_sel_ff == BW'(BK)));
      assign frozen = gate_ctl_ff[GC_RESTART_BIT];
      // enable edge restarts / only this lane
      assign start  = (en & ~en_q_ff) | restart_hit[gl];
      assign expire = run_ff & ~frozen & tick_ff & (gate_s != 3'h0) &
                      (sec_ff + 3'h1 == gate_s);
      assign flag_set[gl] = expire;
      // A lane restarted or disabled in its expiry cycle does not publish.
      assign publish = expire & en & ~start;
      assign active  = run_ff & ~frozen & en & ~start & ~expire;

      // Gate timer and run state.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          en_q_ff <= 1'b0;
          sec_ff  <= '0;
          run_ff  <= 1'b0;
        end else if (clk_en) begin
          en_q_ff <= en;
          if (start) begin
            sec_ff <= '0;
            run_ff <= 1'b1;
          end else if (!en) begin
            run_ff <= 1'b0;
          end else if (publish) begin
            if (auto_on) begin
              sec_ff <= '0;
            end else begin
              run_ff <= 1'b0;
            end
          end else if (active && tick_ff) begin
            sec_ff <= sec_ff + 3'h1;
          end
        end
      end

      // Error counter; it saturates so that a long gate never wraps to a low count.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          err_ff <= '0;
        end else if (clk_en) begin
          if (start) begin
            err_ff <= '0;
          end else if (publish && auto_on) begin
            err_ff <= '0;
          end else if (active && err_pulse[gl] && err_ff != '1) begin
            err_ff <= err_ff + CNT_W'(1);
          end
        end
      end

      // Result sets.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          live_ff <= '0;
          done_ff <= '0;
        end else if (clk_en) begin
          if (publish) begin
            live_ff <= err_ff;
            if (auto_on) begin
              done_ff <= err_ff;
            end
          end else if (active && rt_tick_ff && CAP_WORD[CAP_RT_BIT]) begin
            live_ff <= err_ff;
          end
        end
      end

      assign result_live[gl*CNT_W +: CNT_W] = live_ff;
      assign result_done[gl*CNT_W +: CNT_W] = done_ff;
    end
  endgenerate

  assign pready        = pready_ff;
  assign prdata        = prdata_ff;
  assign pslverr       = pslverr_ff;
  assign gate_done_any = gate_any_ff;

endmodule

// File: sim/gate_timer_monitor.sv
// Assertion checker for the gate timer block's APB and completion flag ports.
// Assumes clk_en is high whenever transfers are in flight.
`timescale 1ns/10ps
module gate_timer_monitor
  import gate_timer_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        clk_en,
  // APB and flag
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        gate_done_any
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  take_to_ready_a: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("request not answered in one cycle");
  ready_one_cycle_a: assert property (pready && clk_en |=> !pready)
    else $error("ready held too long");
  ready_has_cause_a: assert property (pready |-> $past(psel && penable) && psel && penable)
    else $error("ready without request");
  cap_word_a: assert property (pready && !pwrite && paddr == OFS_CAP |-> prdata == 32'h14)
    else $error("capability word wrong");
  bank_cap_off_a: assert property (pready && !pwrite && paddr == OFS_CAP |-> !prdata[CAP_BANK_BIT])
    else $error("bank timer capability set");
  unmapped_err_a: assert property (pready && paddr > OFS_STATUS |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr <= OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  flag_summary_a: assert property (pready && !pwrite && paddr == OFS_FLAGS |->
    (prdata != 32'h0) == $past(gate_done_any))
    else $error("flag summary disagrees with flags");
  cap_read_c: cover property (pready && !pwrite && paddr == OFS_CAP);
  flag_seen_c: cover property (pready && paddr == OFS_FLAGS && gate_done_any);
  refuse_c: cover property (pready && pslverr);
endmodule

bind gated_prbs_lane_timers gate_timer_monitor i_gate_timer_monitor (.clk_sys, .rst_b,
  .clk_en, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .gate_done_any);

// File: sim/apb_host_model.sv
// Host management model: an APB master issuing register transfers.
// Assumes the bench calls xfer only after reset has been released.
`timescale 1ns/10ps
module apb_host_model (
  // Clock
  input  wire logic        clk_sys,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // register writes and register reads
  // The request is held until pready, so no wait count is assumed.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the per-lane gate timers with a host model.
// Assumes a 25 MHz clock and a one-second tick shortened to 20 cycles.
`timescale 1ns/10ps
module tb
  import gate_timer_pkg::*;
;
  logic            clk_sys = 1'b0;
  logic            rst_b = 1'b0;
  logic            clk_en = 1'b1;
  logic            psel, penable, pwrite, pready, pslverr, gate_done_any, e;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, q;
  logic [63:0]     err_pulse = 64'h0;
  logic [1535:0]   result_live, result_done;
  int              n_fail = 0, tests_run = 0, cycles = 0, n, m;

  always #20 clk_sys = ~clk_sys;

  gated_prbs_lane_timers #(.TICK_CYCS(20)) i_gated_prbs_lane_timers (.clk_sys, .rst_b,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .err_pulse, .result_live, .result_done, .gate_done_any);
  apb_host_model i_apb_host_model (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr);

  task results();
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_apb_host_model.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    i_apb_host_model.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // Random errors on every lane for eight cycles; the model counts lane 0 only.
  task burst(output int c);
    logic [63:0] r;
    c = 0;
    repeat (8) begin
      @(posedge clk_sys);
      r = {$urandom, $urandom};
      err_pulse <= r;
      c += r[0];
    end
    @(posedge clk_sys);
    err_pulse <= 64'h0;
  endtask
  // Skip two edges first so that a flag cleared just before is not seen stale.
  task wait_done();
    int i;
    i = 0;
    repeat (2) @(posedge clk_sys);
    while (gate_done_any !== 1'b1 && i < 400) begin
      @(posedge clk_sys);
      i++;
    end
    chk(gate_done_any, 1'b1);
    repeat (3) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    n = $urandom(32'h1bad);
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFS_CAP);
    chk(q, 32'h14);
    wr(OFS_CAP, 32'h0);
    rd(OFS_CAP);
    chk(q, 32'h14);
    rd(8'h40);
    chk({q[30:0], e}, 32'h1);
    wr(OFS_GATE_CTL, 32'h0e);
    wr(OFS_FLAGS, 32'hffffffff);
    wr(OFS_HOST_EN, 32'h1);
    burst(n);
    repeat (45) @(posedge clk_sys);
    chk(result_live[23:0], n);
    wait_done();
    rd(OFS_FLAGS);
    chk(q, 32'h1);
    chk(result_live[23:0], n);
    chk(result_live[47:24], 32'h0);
    burst(m);
    chk(result_live[23:0], n);
    wr(OFS_HOST_EN, 32'h0);
    burst(m);
    chk(result_live[23:0], n);
    wr(OFS_GATE_CTL, 32'h04);
    wr(OFS_FLAGS, 32'hffffffff);
    wr(OFS_HOST_EN, 32'h1);
    burst(m);
    wait_done();
    chk(result_live[23:0], m);
    wr(OFS_FLAGS, 32'hffffffff);
    wr(OFS_HOST_EN, 32'h0);
    wr(OFS_HOST_EN, 32'h1);
    wr(OFS_GATE_CTL, 32'h24);
    burst(m);
    repeat (100) @(posedge clk_sys);
    chk(gate_done_any, 1'b0);
    wr(OFS_GATE_CTL, 32'h04);
    burst(n);
    // Clock enable low must stop the tick, so the running gate cannot expire.
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (100) @(posedge clk_sys);
    chk(gate_done_any, 1'b0);
    clk_en <= 1'b1;
    wait_done();
    chk(result_live[23:0], n);
    // Per-bank timers are not offered, so the scope bit must not reach bank 0.
    wr(OFS_BANK, 32'h0000_0101);
    wr(OFS_GATE_CTL, 32'ha4);
    wr(OFS_FLAGS, 32'hffffffff);
    wr(OFS_GATE_CTL, 32'h84);
    repeat (100) @(posedge clk_sys);
    chk(gate_done_any, 1'b0);
    wr(OFS_GATE_CTL, 32'h14);
    wr(OFS_HOST_EN, 32'h0);
    wr(OFS_FLAGS, 32'hffffffff);
    wr(OFS_HOST_EN, 32'h1);
    burst(m);
    wait_done();
    chk(result_done[23:0], m);
    wr(OFS_FLAGS, 32'hffffffff);
    wait_done();
    chk(result_done[23:0], 32'h0);
    results();
  end
endmodule
